// >>> verilog/rng_and_secure_supply_switch_ctrl.sv
`timescale 1ns/100ps
//
// Contract
// RQ1 - 8-bit read/write register holds latest random value
// RQ2 - fresh flag set when new value loaded
// RQ3 - reading random value clears fresh flag
// RQ4 - force bit 0: contactless unit runs generator
// RQ5 - mask bit 0: internal pins follow pads
// RQ6 - mask bit 1: secure input 0, aux 1
// RQ7 - firmware masks pins around supply switching
// RQ8 - overload bit reads current limitation state
// RQ9 - switch enable 0: supply off, rail grounded
// RQ10 - switch enable 1: supply rail powers pads
// RQ11 - new values only while generator runs
//
module rng_and_secure_supply_switch_ctrl
   import rng_pkg::*;
#(
   parameter int PERIOD = RNG_PERIOD
)(
   // clock, reset, enable
   input  wire logic              core_clk,
   input  wire logic              rst_n,
   input  wire logic              clk_en,
   // register port
   input  wire reg_bus_s          bus_in,
   output      logic [DATA_W-1:0] rd_data,
   // pads and analog status
   input  wire pad_s              pads,
   input  wire logic              switch_overload,
   input  wire logic              contactless_interface_unit_run,
   // internal pin levels, supply control, run state and interrupt
   output      pad_s              internal_pins,
   output      logic              supply_switch_en,
   output      logic              supply_rail_ground,
   output      logic              rng_running,
   output      logic              irq
);

   // ------------------------------------------------------------
   // parameter check
   // ------------------------------------------------------------
   if (PERIOD < 1 || PERIOD > (1 << CNT_W) - 1) begin : g_bad_period
      $error("PERIOD must lie in 1 .. 255");
   end

   localparam logic [CNT_W-1:0] LAST_CNT = CNT_W'(PERIOD - 1);

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   state_s           st_ff;
   state_s           nxt_st;
   logic             running;
   logic             load;
   logic             wr_rv;
   logic             wr_ctrl;
   logic             wr_stat;
   logic             wr_mask;
   logic             rd_rv;
   logic [7:0]       ctrl_view;
   logic [DATA_W-1:0] rd_mux;
   logic [IRQ_W-1:0] irq_events;

   assign running = st_ff.force_run | contactless_interface_unit_run; // [RQ4]
   assign load    = running && st_ff.period_cnt == LAST_CNT;          // [RQ11]

   assign wr_rv   = bus_in.wr && bus_in.addr == RANDOM_VALUE_ADDR;
   assign wr_ctrl = bus_in.wr && bus_in.addr == SWITCH_CTRL_ADDR;
   assign wr_stat = bus_in.wr && bus_in.addr == IRQ_STATUS_ADDR;
   assign wr_mask = bus_in.wr && bus_in.addr == IRQ_MASK_ADDR;
   assign rd_rv   = bus_in.rd && bus_in.addr == RANDOM_VALUE_ADDR;

   // ------------------------------------------------------------
   // control register view
   // ------------------------------------------------------------
   always_comb begin
      ctrl_view                    = 8'h00;
      ctrl_view[CTRL_RSVD0_BIT]    = CTRL_RESET[CTRL_RSVD0_BIT];
      ctrl_view[CTRL_FRESH_BIT]    = st_ff.fresh;
      ctrl_view[CTRL_FORCE_BIT]    = st_ff.force_run;
      ctrl_view[CTRL_SWITCH_BIT]   = st_ff.switch_en;
      ctrl_view[CTRL_OVERLOAD_BIT] = st_ff.overload;                  // [RQ8]
      ctrl_view[CTRL_MASK_BIT]     = st_ff.mask_pins;
   end

   always_comb begin
      case (bus_in.addr)
         RANDOM_VALUE_ADDR: rd_mux = st_ff.random_value;
         SWITCH_CTRL_ADDR:  rd_mux = ctrl_view;
         IRQ_STATUS_ADDR:   rd_mux = {{(DATA_W-IRQ_W){1'b0}},
                                      st_ff.irq_status};
         IRQ_MASK_ADDR:     rd_mux = {{(DATA_W-IRQ_W){1'b0}},
                                      st_ff.irq_mask};
         default:           rd_mux = '0;
      endcase
   end

   // ------------------------------------------------------------
   // interrupt events
   // ------------------------------------------------------------
   always_comb begin
      irq_events                   = '0;
      irq_events[IRQ_FRESH_BIT]    = load;
      irq_events[IRQ_OVERLOAD_BIT] = switch_overload & ~st_ff.overload;
   end

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      nxt_st = st_ff;

      // generator runs only while enabled
      if (running) begin                                              // [RQ11]
         nxt_st.lfsr = {1'b0, st_ff.lfsr[15:1]}
                       ^ (st_ff.lfsr[0] ? LFSR_TAPS : 16'h0000);
         nxt_st.period_cnt = load ? '0 : st_ff.period_cnt + 1'b1;
      end

      // random value: software write, generator load wins
      if (wr_rv) begin
         nxt_st.random_value = bus_in.wdata;                          // [RQ1]
      end
      if (load) begin
         nxt_st.random_value = st_ff.lfsr[7:0];                       // [RQ1]
      end

      // fresh flag: clear by read, control write loads it, set wins
      if (rd_rv) begin
         nxt_st.fresh = 1'b0;                                         // [RQ3]
      end
      if (wr_ctrl) begin
         nxt_st.fresh     = bus_in.wdata[CTRL_FRESH_BIT];
         nxt_st.force_run = bus_in.wdata[CTRL_FORCE_BIT];             // [RQ4]
         nxt_st.switch_en = bus_in.wdata[CTRL_SWITCH_BIT];
         nxt_st.mask_pins = bus_in.wdata[CTRL_MASK_BIT];
      end
      if (load) begin
         nxt_st.fresh = 1'b1;                                         // [RQ2]
      end

      nxt_st.overload = switch_overload;                              // [RQ8]

      // sticky status, write one clears, set wins
      if (wr_stat) begin
         nxt_st.irq_status = st_ff.irq_status & ~bus_in.wdata[IRQ_W-1:0];
      end
      nxt_st.irq_status = nxt_st.irq_status | irq_events;
      if (wr_mask) begin
         nxt_st.irq_mask = bus_in.wdata[IRQ_W-1:0];
      end

      // internal pin levels, idle while masked
      if (st_ff.mask_pins) begin
         nxt_st.internal_pins.secure_input_pin = 1'b0;                // [RQ6]
         nxt_st.internal_pins.aux_port_pin     = 1'b1;                // [RQ6]
      end else begin
         nxt_st.internal_pins = pads;                                 // [RQ5]
      end

      // read data stand one cycle only
      nxt_st.rd_data = bus_in.rd ? rd_mux : '0;
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         st_ff                <= '0;
         st_ff.lfsr           <= LFSR_SEED;
         st_ff.random_value   <= RANDOM_RESET;
         st_ff.fresh          <= CTRL_RESET[CTRL_FRESH_BIT];
         st_ff.force_run      <= CTRL_RESET[CTRL_FORCE_BIT];
         st_ff.switch_en      <= CTRL_RESET[CTRL_SWITCH_BIT];
         st_ff.overload       <= CTRL_RESET[CTRL_OVERLOAD_BIT];
         st_ff.mask_pins      <= CTRL_RESET[CTRL_MASK_BIT];
         st_ff.irq_status     <= IRQ_RESET;
         st_ff.irq_mask       <= IRQ_RESET;
         st_ff.internal_pins.secure_input_pin <= 1'b0;
         st_ff.internal_pins.aux_port_pin     <= 1'b1;
      end else if (clk_en) begin
         st_ff <= nxt_st;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign rd_data            = st_ff.rd_data;
   assign internal_pins      = st_ff.internal_pins;
   assign supply_switch_en   = st_ff.switch_en;                       // [RQ10]
   assign supply_rail_ground = ~st_ff.switch_en;                      // [RQ9]
   assign rng_running        = running;
   assign irq                = |(st_ff.irq_status & st_ff.irq_mask);

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   property p_rv_write;
      @(posedge core_clk) disable iff (!rst_n)
      clk_en && wr_rv && !load
      |=> st_ff.random_value == $past(bus_in.wdata);
   endproperty
   a_rv_write: assert property (p_rv_write) // [RQ1]
      else $error("random value write not stored");

   property p_load_sets_fresh;
      @(posedge core_clk) disable iff (!rst_n)
      clk_en && load
      |=> st_ff.fresh && st_ff.random_value == $past(st_ff.lfsr[7:0]);
   endproperty
   a_load_sets_fresh: assert property (p_load_sets_fresh) // [RQ2]
      else $error("load did not raise fresh flag with new value");

   property p_read_clears;
      @(posedge core_clk) disable iff (!rst_n)
      clk_en && rd_rv && !load && !wr_ctrl
      |=> !st_ff.fresh;
   endproperty
   a_read_clears: assert property (p_read_clears) // [RQ3]
      else $error("random value read left fresh flag set");

   property p_running;
      @(posedge core_clk) disable iff (!rst_n)
      clk_en && wr_ctrl
      |=> st_ff.force_run == $past(bus_in.wdata[CTRL_FORCE_BIT])
          && (!st_ff.force_run || rng_running);
   endproperty
   a_running: assert property (p_running) // [RQ4]
      else $error("generator run state wrong");

   property p_pins_follow;
      @(posedge core_clk) disable iff (!rst_n)
      clk_en && !st_ff.mask_pins
      |=> internal_pins == $past(pads);
   endproperty
   a_pins_follow: assert property (p_pins_follow) // [RQ5]
      else $error("internal pins do not follow pads");

   property p_pins_masked;
      @(posedge core_clk) disable iff (!rst_n)
      clk_en && st_ff.mask_pins
      |=> !internal_pins.secure_input_pin
          && internal_pins.aux_port_pin;
   endproperty
   a_pins_masked: assert property (p_pins_masked) // [RQ6]
      else $error("masked pins not at idle levels");

   property p_overload;
      @(posedge core_clk) disable iff (!rst_n)
      clk_en ##1 bus_in.rd && bus_in.addr == SWITCH_CTRL_ADDR && clk_en
      |=> rd_data[CTRL_OVERLOAD_BIT] == $past(switch_overload, 2);
   endproperty
   a_overload: assert property (p_overload) // [RQ8]
      else $error("overload bit does not track limitation");

   property p_switch_off;
      @(posedge core_clk) disable iff (!rst_n)
      clk_en && wr_ctrl && !bus_in.wdata[CTRL_SWITCH_BIT]
      |=> !supply_switch_en && supply_rail_ground;
   endproperty
   a_switch_off: assert property (p_switch_off) // [RQ9]
      else $error("rail not grounded while switch off");

   property p_switch_on;
      @(posedge core_clk) disable iff (!rst_n)
      clk_en && wr_ctrl && bus_in.wdata[CTRL_SWITCH_BIT]
      |=> supply_switch_en && !supply_rail_ground;
   endproperty
   a_switch_on: assert property (p_switch_on) // [RQ10]
      else $error("switch enable write did not power rail");

   property p_idle_no_value;
      @(posedge core_clk) disable iff (!rst_n)
      clk_en && !running && !wr_rv
      |=> $stable(st_ff.random_value);
   endproperty
   a_idle_no_value: assert property (p_idle_no_value) // [RQ11]
      else $error("new value while generator stopped");

   property p_rd_timing;
      @(posedge core_clk) disable iff (!rst_n)
      clk_en && !bus_in.rd |=> rd_data == '0;
   endproperty
   a_rd_timing: assert property (p_rd_timing)
      else $error("read data outside answer cycle");

   property p_rd_answer;
      @(posedge core_clk) disable iff (!rst_n)
      clk_en && rd_rv
      |=> rd_data == $past(st_ff.random_value);
   endproperty
   a_rd_answer: assert property (p_rd_answer) // [RQ1]
      else $error("random value read returned wrong data");

   property p_fresh_hold;
      @(posedge core_clk) disable iff (!rst_n)
      clk_en && st_ff.fresh && !rd_rv && !wr_ctrl
      |=> st_ff.fresh;
   endproperty
   a_fresh_hold: assert property (p_fresh_hold) // [RQ2]
      else $error("fresh flag dropped without a read");

   property p_stopped_hold;
      @(posedge core_clk) disable iff (!rst_n)
      clk_en && !running
      |=> $stable(st_ff.lfsr) && $stable(st_ff.period_cnt);
   endproperty
   a_stopped_hold: assert property (p_stopped_hold) // [RQ11]
      else $error("generator advanced while stopped");

   property p_freeze;
      @(posedge core_clk) disable iff (!rst_n)
      !clk_en |=> $stable(st_ff);
   endproperty
   a_freeze: assert property (p_freeze)
      else $error("state changed while clock enable low");

   property p_load_event;
      @(posedge core_clk) disable iff (!rst_n)
      clk_en && load
      |=> st_ff.irq_status[IRQ_FRESH_BIT];
   endproperty
   a_load_event: assert property (p_load_event) // [RQ2]
      else $error("load did not set its status bit");

   property p_overload_event;
      @(posedge core_clk) disable iff (!rst_n)
      clk_en && switch_overload && !st_ff.overload
      |=> st_ff.irq_status[IRQ_OVERLOAD_BIT];
   endproperty
   a_overload_event: assert property (p_overload_event) // [RQ8]
      else $error("overload onset did not set its status bit");

   property p_status_sticky;
      @(posedge core_clk) disable iff (!rst_n)
      clk_en && !wr_stat
      |=> (st_ff.irq_status & $past(st_ff.irq_status))
          == $past(st_ff.irq_status);
   endproperty
   a_status_sticky: assert property (p_status_sticky)
      else $error("status bit cleared without a write");

   property p_status_clear;
      @(posedge core_clk) disable iff (!rst_n)
      clk_en && wr_stat && bus_in.wdata[IRQ_FRESH_BIT] && !load
      |=> !st_ff.irq_status[IRQ_FRESH_BIT];
   endproperty
   a_status_clear: assert property (p_status_clear)
      else $error("write one did not clear status bit");

endmodule : rng_and_secure_supply_switch_ctrl

// >>> verilog/rng_pkg.sv
package rng_pkg;

   // ------------------------------------------------------------
   // register bus
   // ------------------------------------------------------------
   localparam int          ADDR_W            = 16;
   localparam int          DATA_W            = 8;
   localparam logic [15:0] RANDOM_VALUE_ADDR = 16'h6105;
   localparam logic [15:0] SWITCH_CTRL_ADDR  = 16'h6106;
   localparam logic [15:0] IRQ_STATUS_ADDR   = 16'h6107;
   localparam logic [15:0] IRQ_MASK_ADDR     = 16'h6108;

   // ------------------------------------------------------------
   // control register fields
   // ------------------------------------------------------------
   localparam int         CTRL_RSVD0_BIT    = 0;
   localparam int         CTRL_FRESH_BIT    = 1;
   localparam int         CTRL_FORCE_BIT    = 2;
   localparam int         CTRL_SWITCH_BIT   = 4;
   localparam int         CTRL_OVERLOAD_BIT = 5;
   localparam int         CTRL_MASK_BIT     = 6;
   localparam logic [7:0] CTRL_RESET        = 8'h41;
   localparam logic [7:0] RANDOM_RESET      = 8'h00;

   // ------------------------------------------------------------
   // interrupt status and mask fields
   // ------------------------------------------------------------
   localparam int         IRQ_W            = 2;
   localparam int         IRQ_FRESH_BIT    = 0;
   localparam int         IRQ_OVERLOAD_BIT = 1;
   localparam logic [1:0] IRQ_RESET        = 2'h0;

   // ------------------------------------------------------------
   // generator
   // ------------------------------------------------------------
   localparam int          CNT_W        = 8;
   localparam int          RNG_PERIOD   = 8;
   localparam logic [15:0] LFSR_SEED    = 16'hace1;
   localparam logic [15:0] LFSR_TAPS    = 16'hb400;

   // ------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } reg_bus_s;

   typedef struct packed {
      logic secure_input_pin;
      logic aux_port_pin;
   } pad_s;

   typedef struct packed {
      logic [15:0]       lfsr;
      logic [CNT_W-1:0]  period_cnt;
      logic [7:0]        random_value;
      logic              fresh;
      logic              force_run;
      logic              switch_en;
      logic              overload;
      logic              mask_pins;
      logic [IRQ_W-1:0]  irq_status;
      logic [IRQ_W-1:0]  irq_mask;
      pad_s              internal_pins;
      logic [DATA_W-1:0] rd_data;
   } state_s;

endpackage : rng_pkg

// >>> verification/tb.sv
`timescale 1ns/100ps
module tb;
   import rng_pkg::*;

   // ------------------------------------------------------------
   // signals
   // ------------------------------------------------------------
   localparam int     PER = 2;
   logic              core_clk;
   logic              rst_n;
   logic              clk_en;
   reg_bus_s          bus_in;
   logic [DATA_W-1:0] rd_data;
   pad_s              pads;
   pad_s              internal_pins;
   logic              switch_overload;
   logic              contactless_interface_unit_run;
   logic              supply_switch_en;
   logic              supply_rail_ground;
   logic              rng_running;
   logic              irq;
   int                bad_count;
   int                cmp_count;
   int                cycles;
   logic [7:0]        rv;

   rng_and_secure_supply_switch_ctrl #(.PERIOD(PER))
      rng_and_secure_supply_switch_ctrl_inst (
      .core_clk                       (core_clk),
      .rst_n                          (rst_n),
      .clk_en                         (clk_en),
      .bus_in                         (bus_in),
      .rd_data                        (rd_data),
      .pads                           (pads),
      .switch_overload                (switch_overload),
      .contactless_interface_unit_run (contactless_interface_unit_run),
      .internal_pins                  (internal_pins),
      .supply_switch_en               (supply_switch_en),
      .supply_rail_ground             (supply_rail_ground),
      .rng_running                    (rng_running),
      .irq                            (irq)
   );

   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task automatic conclude();
      $display("bad_count=%0d cmp_count=%0d", bad_count, cmp_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : conclude

   always @(posedge core_clk) begin
      cycles = cycles + 1;
      if (cycles == 5000) begin
         bad_count = bad_count + 1;
         conclude();
      end
   end

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
         bad_count = bad_count + 1;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge core_clk);
      bus_in.addr  <= a;
      bus_in.wdata <= d;
      bus_in.wr    <= 1'b1;
      @(posedge core_clk);
      bus_in.wr    <= 1'b0;
   endtask : wr

   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      @(posedge core_clk);
      bus_in.addr <= a;
      bus_in.rd   <= 1'b1;
      @(posedge core_clk);
      bus_in.rd   <= 1'b0;
      #1 d = rd_data;
   endtask : rd

   task automatic rdchk(input logic [15:0] a, input logic [7:0] exp);
      logic [7:0] d;
      rd(a, d);
      check(d, exp);
   endtask : rdchk

   task automatic after(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : after

   task automatic setpads(input logic s, input logic x);
      @(posedge core_clk);
      pads.secure_input_pin <= s;
      pads.aux_port_pin     <= x;
   endtask : setpads

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_reset();
      rdchk(SWITCH_CTRL_ADDR, CTRL_RESET);
      rdchk(RANDOM_VALUE_ADDR, RANDOM_RESET);
      rdchk(IRQ_STATUS_ADDR, 8'h00);
      rdchk(16'h6109, 8'h00);
      check({7'h00, internal_pins.secure_input_pin}, 8'h00);
      check({7'h00, internal_pins.aux_port_pin}, 8'h01);
      check({7'h00, supply_rail_ground}, 8'h01);
      check({7'h00, irq}, 8'h00);
   endtask : t_reset

   task automatic t_random_rw();
      wr(RANDOM_VALUE_ADDR, 8'h5a);
      rdchk(RANDOM_VALUE_ADDR, 8'h5a);
      wr(RANDOM_VALUE_ADDR, 8'ha5);
      after(8);
      rdchk(SWITCH_CTRL_ADDR, 8'h41);
      rdchk(RANDOM_VALUE_ADDR, 8'ha5);
      wr(SWITCH_CTRL_ADDR, 8'h42);
      rdchk(SWITCH_CTRL_ADDR, 8'h43);
      rdchk(RANDOM_VALUE_ADDR, 8'ha5);
      rdchk(SWITCH_CTRL_ADDR, 8'h41);
   endtask : t_random_rw

   task automatic t_pins();
      wr(SWITCH_CTRL_ADDR, 8'h00);
      setpads(1'b1, 1'b0);
      after(3);
      check({6'h00, internal_pins}, 8'h02);
      setpads(1'b0, 1'b1);
      after(2);
      check({6'h00, internal_pins}, 8'h01);
      setpads(1'b1, 1'b0);
      wr(SWITCH_CTRL_ADDR, 8'h40);
      after(2);
      check({6'h00, internal_pins}, 8'h01);
   endtask : t_pins

   task automatic t_switch();
      // pins stay hidden while the supply toggles
      wr(SWITCH_CTRL_ADDR, 8'h50);
      after(1);
      check({6'h00, supply_switch_en, supply_rail_ground}, 8'h02);
      rdchk(SWITCH_CTRL_ADDR, 8'h51);
      wr(SWITCH_CTRL_ADDR, 8'h40);
      after(1);
      check({6'h00, supply_switch_en, supply_rail_ground}, 8'h01);
      wr(SWITCH_CTRL_ADDR, 8'h00);
   endtask : t_switch

   task automatic t_unit_run();
      @(posedge core_clk);
      contactless_interface_unit_run <= 1'b1;
      after(1);
      check({7'h00, rng_running}, 8'h01);
      after(3 * PER);
      @(posedge core_clk);
      contactless_interface_unit_run <= 1'b0;
      after(2);
      check({7'h00, rng_running}, 8'h00);
      rdchk(SWITCH_CTRL_ADDR, 8'h03);
      rdchk(IRQ_STATUS_ADDR, 8'h01);
      wr(IRQ_MASK_ADDR, 8'h01);
      after(1);
      check({7'h00, irq}, 8'h01);
      wr(IRQ_MASK_ADDR, 8'h00);
      after(1);
      check({7'h00, irq}, 8'h00);
      wr(IRQ_MASK_ADDR, 8'h01);
      wr(IRQ_STATUS_ADDR, 8'h01);
      after(1);
      check({7'h00, irq}, 8'h00);
      rd(RANDOM_VALUE_ADDR, rv);
      rdchk(SWITCH_CTRL_ADDR, 8'h01);
      @(posedge core_clk);
      clk_en <= 1'b0;
      wr(RANDOM_VALUE_ADDR, rv ^ 8'hff);
      @(posedge core_clk);
      clk_en <= 1'b1;
      after(6);
      rdchk(RANDOM_VALUE_ADDR, rv);
   endtask : t_unit_run

   task automatic t_force();
      wr(SWITCH_CTRL_ADDR, 8'h04);
      after(1);
      check({7'h00, rng_running}, 8'h01);
      after(3 * PER);
      rdchk(SWITCH_CTRL_ADDR, 8'h07);
      wr(SWITCH_CTRL_ADDR, 8'h00);
      after(1);
      check({7'h00, rng_running}, 8'h00);
      rd(RANDOM_VALUE_ADDR, rv);
      after(2 * PER);
      rdchk(SWITCH_CTRL_ADDR, 8'h01);
   endtask : t_force

   task automatic t_overload();
      wr(IRQ_STATUS_ADDR, 8'h03);
      wr(IRQ_MASK_ADDR, 8'h02);
      @(posedge core_clk);
      switch_overload <= 1'b1;
      after(2);
      rdchk(SWITCH_CTRL_ADDR, 8'h21);
      check({7'h00, irq}, 8'h01);
      rdchk(IRQ_STATUS_ADDR, 8'h02);
      wr(SWITCH_CTRL_ADDR, 8'h00);
      rdchk(SWITCH_CTRL_ADDR, 8'h21);
      @(posedge core_clk);
      switch_overload <= 1'b0;
      after(2);
      rdchk(SWITCH_CTRL_ADDR, 8'h01);
      wr(IRQ_STATUS_ADDR, 8'h02);
      after(1);
      check({7'h00, irq}, 8'h00);
   endtask : t_overload

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      bad_count = 0;
      cmp_count = 0;
      cycles    = 0;
      rst_n     = 1'b0;
      clk_en    = 1'b1;
      bus_in    = '0;
      pads      = '0;
      switch_overload                = 1'b0;
      contactless_interface_unit_run = 1'b0;
      repeat (20) @(posedge core_clk);
      rst_n <= 1'b1;
      t_reset();
      t_random_rw();
      t_pins();
      t_switch();
      t_unit_run();
      t_force();
      t_overload();
      conclude();
   end

endmodule : tb
